// [core/mse_pkg.sv]
// shared constants for the moderate and severe fault flag block
package mse_pkg;

  localparam int unsigned DATA_W = 8;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODERATE  = 8'h67;
  localparam logic [7:0] IDX_SEVERE    = 8'h68;
  localparam logic [7:0] IDX_MOD_MASK  = 8'h80;
  localparam logic [7:0] IDX_SEV_MASK  = 8'h81;
  localparam logic [7:0] IDX_LIVE      = 8'h82;

  localparam logic [7:0] MODERATE_RST  = 8'h00;
  localparam logic [7:0] SEVERE_RST    = 8'h00;
  localparam logic [7:0] MASK_RST      = 8'h00;

  // moderate fault flag bit positions
  localparam int unsigned MOD_RST_PIN  = 7;
  localparam int unsigned MOD_IRQ_PIN  = 6;
  localparam int unsigned MOD_RSVD     = 5;
  localparam int unsigned MOD_LINK     = 4;
  localparam int unsigned MOD_RECOV    = 3;
  localparam int unsigned MOD_CRC      = 2;
  localparam int unsigned MOD_BIST     = 1;
  localparam int unsigned MOD_TSD_SEQ  = 0;

  // severe fault flag bit positions
  localparam int unsigned SEV_SEQR     = 2;
  localparam int unsigned SEV_OVP      = 1;
  localparam int unsigned SEV_TSD_IMM  = 0;

  // plain read/write reserved bits
  localparam logic [7:0] MOD_RW_MASK   = 8'h20;
  localparam logic [7:0] SEV_RW_MASK   = 8'hF8;

  // live status bit positions
  localparam int unsigned LIVE_TSD_SEQ = 0;
  localparam int unsigned LIVE_TSD_IMM = 1;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// [core/mse_w1c_reg.sv]
// one flag register: write-one-to-clear bits plus plain read/write bits
`timescale 1ns/1ps
`default_nettype none
module mse_w1c_reg #(
  parameter int unsigned     W       = 8,
  parameter logic [W-1:0]    RW_MASK = '0,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  output logic      [W-1:0] q
);

  if (W < 1) begin : g_bad_w
    $error("W must be at least 1");
  end

  logic [W-1:0] flag_q;
  logic [W-1:0] flag_d;
  logic [W-1:0] clr;
  logic [W-1:0] rw_val;

  assign clr    = wr_en ? wr_data : '0;
  assign rw_val = wr_en ? wr_data : flag_q;
  // set is or-ed in after the clear so a coincident event survives
  assign flag_d = (((flag_q & ~clr) | set) & ~RW_MASK) | (rw_val & RW_MASK);
  assign q      = flag_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= RST_VAL;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule
`default_nettype wire

// [core/mse_flags.sv]
// moderate and severe fault flags with ahb-lite slave and interrupt
//
// How it works
// - reset output pin read-back mismatch sets moderate bit 7, held
// - interrupt output pin read-back mismatch sets moderate bit 6
// - pmic link error sets moderate bit 4
// - recovery counter equal to threshold sets moderate bit 3
// - register crc mismatch sets moderate bit 2
// - logic or analog self-test failure sets moderate bit 1
// - sequenced thermal level sets moderate bit 0, orders sequenced off
// - no regulator enable while either thermal flag is set
// - live thermal conditions readable in a separate unlatched register
// - power sequencer error sets severe bit 2
// - supply over-voltage sets severe bit 1 and disables regulators
// - immediate thermal level sets severe bit 0, disables regulators
// - writing one clears that flag bit; zeros leave flag bits alone
// - severe register at index 0x68, reset zero, bits 7:3 plain r/w
// - moderate register at index 0x67, reset zero
`timescale 1ns/1ps
`default_nettype none
module mse_flags #(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic             hready,
  input  wire logic [31:0]      hwdata,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // fault detector inputs, active high levels
  input  wire logic             reset_pin_readback_err,
  input  wire logic             irq_pin_readback_err,
  input  wire logic             pmic_link_err,
  input  wire logic [CNT_W-1:0] recovery_counter,
  input  wire logic [CNT_W-1:0] recovery_threshold,
  input  wire logic             reg_crc_err,
  input  wire logic             logic_self_test_fail,
  input  wire logic             analog_self_test_fail,
  input  wire logic             thermal_sequenced_live,
  input  wire logic             sequencer_err,
  input  wire logic             supply_overvoltage,
  input  wire logic             thermal_immediate_live,
  // regulator control
  input  wire logic             regulator_enable_req,
  output logic                  regulator_enable,
  output logic                  sequenced_shutdown,
  output logic                  immediate_shutdown,
  output logic                  irq
);

  if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt_w
    $error("CNT_W must be 1 to 16");
  end

  localparam int unsigned W = mse_pkg::DATA_W;

  // ---------------- bus slave ----------------
  logic       dp_wr_q;
  logic       dp_rd_q;
  logic [7:0] dp_idx_q;
  logic       dp_mapped_q;
  wire logic  addr_take;
  wire logic  idx_hi_zero;
  wire logic [7:0] ap_idx;

  assign addr_take   = hsel & hready & htrans[1];
  assign ap_idx      = haddr[9:2];
  assign idx_hi_zero = (haddr[31:10] == 22'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_wr_q     <= 1'b0;
      dp_rd_q     <= 1'b0;
      dp_idx_q    <= 8'h00;
      dp_mapped_q <= 1'b0;
    end else begin
      dp_wr_q     <= addr_take & hwrite;
      dp_rd_q     <= addr_take & ~hwrite;
      dp_idx_q    <= addr_take ? ap_idx : dp_idx_q;
      dp_mapped_q <= addr_take & idx_hi_zero;
    end
  end

  // zero wait states: every data phase completes in one cycle
  assign hreadyout = 1'b1;
  assign hresp     = mse_pkg::HRESP_OKAY;

  wire logic wr_mod;
  wire logic wr_sev;
  wire logic wr_mod_mask;
  wire logic wr_sev_mask;
  wire logic [W-1:0] wdat;

  assign wdat        = hwdata[W-1:0];
  assign wr_mod      = dp_wr_q & dp_mapped_q &
                       (dp_idx_q == mse_pkg::IDX_MODERATE);
  assign wr_sev      = dp_wr_q & dp_mapped_q &
                       (dp_idx_q == mse_pkg::IDX_SEVERE);
  assign wr_mod_mask = dp_wr_q & dp_mapped_q &
                       (dp_idx_q == mse_pkg::IDX_MOD_MASK);
  assign wr_sev_mask = dp_wr_q & dp_mapped_q &
                       (dp_idx_q == mse_pkg::IDX_SEV_MASK);

  // ---------------- event sources ----------------
  logic [W-1:0] mod_set;
  logic [W-1:0] sev_set;
  wire logic    recov_hit;

  assign recov_hit = (recovery_counter == recovery_threshold);

  always_comb begin
    mod_set = '0;
    mod_set[mse_pkg::MOD_RST_PIN] = reset_pin_readback_err;
    mod_set[mse_pkg::MOD_IRQ_PIN] = irq_pin_readback_err;
    mod_set[mse_pkg::MOD_LINK]    = pmic_link_err;
    mod_set[mse_pkg::MOD_RECOV]   = recov_hit;
    mod_set[mse_pkg::MOD_CRC]     = reg_crc_err;
    mod_set[mse_pkg::MOD_BIST]    = logic_self_test_fail |
                                    analog_self_test_fail;
    mod_set[mse_pkg::MOD_TSD_SEQ] = thermal_sequenced_live;
  end

  always_comb begin
    sev_set = '0;
    sev_set[mse_pkg::SEV_SEQR]    = sequencer_err;
    sev_set[mse_pkg::SEV_OVP]     = supply_overvoltage;
    sev_set[mse_pkg::SEV_TSD_IMM] = thermal_immediate_live;
  end

  // ---------------- flag registers ----------------
  logic [W-1:0] mod_q;
  logic [W-1:0] sev_q;

  // w1c with set priority, reserved bit 5 plain r/w
  mse_w1c_reg #(
    .W       (W),
    .RW_MASK (mse_pkg::MOD_RW_MASK),
    .RST_VAL (mse_pkg::MODERATE_RST)
  ) u_moderate (
    .clk     (clk),
    .rst_n   (rst_n),
    .set     (mod_set),
    .wr_en   (wr_mod),
    .wr_data (wdat),
    .q       (mod_q)
  );

  mse_w1c_reg #(
    .W       (W),
    .RW_MASK (mse_pkg::SEV_RW_MASK),
    .RST_VAL (mse_pkg::SEVERE_RST)
  ) u_severe (
    .clk     (clk),
    .rst_n   (rst_n),
    .set     (sev_set),
    .wr_en   (wr_sev),
    .wr_data (wdat),
    .q       (sev_q)
  );

  // ---------------- masks, live status, interrupt ----------------
  logic [W-1:0] mod_mask_q;
  logic [W-1:0] sev_mask_q;
  logic [1:0]   live_q;
  logic         irq_q;
  wire logic    irq_d;

  // reserved bits never raise the interrupt
  assign irq_d = |(mod_q & ~mod_mask_q & ~mse_pkg::MOD_RW_MASK) |
                 |(sev_q & ~sev_mask_q & ~mse_pkg::SEV_RW_MASK);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_mask_q <= mse_pkg::MASK_RST;
      sev_mask_q <= mse_pkg::MASK_RST;
      live_q     <= 2'h0;
      irq_q      <= 1'b0;
    end else begin
      mod_mask_q <= wr_mod_mask ? wdat : mod_mask_q;
      sev_mask_q <= wr_sev_mask ? wdat : sev_mask_q;
      live_q[mse_pkg::LIVE_TSD_SEQ] <= thermal_sequenced_live;
      live_q[mse_pkg::LIVE_TSD_IMM] <= thermal_immediate_live;
      irq_q      <= irq_d;
    end
  end

  assign irq = irq_q;

  // ---------------- regulator control ----------------
  logic      reg_en_q;
  logic      seq_off_q;
  logic      imm_off_q;
  wire logic tsd_block;
  wire logic imm_now;

  // looking at the set terms too closes the one-cycle gap before the flag
  assign tsd_block = mod_q[mse_pkg::MOD_TSD_SEQ] |
                     sev_q[mse_pkg::SEV_TSD_IMM] |
                     thermal_sequenced_live | thermal_immediate_live;
  assign imm_now   = supply_overvoltage | thermal_immediate_live;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_en_q  <= 1'b0;
      seq_off_q <= 1'b0;
      imm_off_q <= 1'b0;
    end else begin
      reg_en_q  <= regulator_enable_req & ~tsd_block & ~imm_now;
      seq_off_q <= thermal_sequenced_live;
      imm_off_q <= imm_now;
    end
  end

  assign regulator_enable   = reg_en_q;
  assign sequenced_shutdown = seq_off_q;
  assign immediate_shutdown = imm_off_q;

  // ---------------- read mux ----------------
  // combinational from flops so a read right after a write sees new data
  logic [W-1:0] rd_byte;

  always_comb begin
    rd_byte = '0;
    if (dp_rd_q && dp_mapped_q) begin
      case (dp_idx_q)
        mse_pkg::IDX_MODERATE: rd_byte = mod_q;
        mse_pkg::IDX_SEVERE:   rd_byte = sev_q;
        mse_pkg::IDX_MOD_MASK: rd_byte = mod_mask_q;
        mse_pkg::IDX_SEV_MASK: rd_byte = sev_mask_q;
        mse_pkg::IDX_LIVE:     rd_byte = {6'h00, live_q};
        default:               rd_byte = '0;
      endcase
    end
  end

  assign hrdata = {24'h000000, rd_byte};

  // ---------------- assertions ----------------
  a_rst_pin_set:
    assert property (@(posedge clk) disable iff (!rst_n)
      reset_pin_readback_err |=> mod_q[7])
    else $error("reset pin read-back did not set moderate bit 7");

  a_irq_pin_set:
    assert property (@(posedge clk) disable iff (!rst_n)
      irq_pin_readback_err |=> mod_q[6])
    else $error("irq pin read-back did not set moderate bit 6");

  a_link_set:
    assert property (@(posedge clk) disable iff (!rst_n)
      pmic_link_err |=> mod_q[4])
    else $error("link error did not set moderate bit 4");

  a_recov_set:
    assert property (@(posedge clk) disable iff (!rst_n)
      (recovery_counter == recovery_threshold) |=> mod_q[3])
    else $error("recovery limit did not set moderate bit 3");

  a_crc_bist_set:
    assert property (@(posedge clk) disable iff (!rst_n)
      (reg_crc_err || logic_self_test_fail || analog_self_test_fail)
      |=> (mod_q[2] || mod_q[1]))
    else $error("crc or self-test failure not latched");

  a_crc_set:
    assert property (@(posedge clk) disable iff (!rst_n)
      reg_crc_err |=> mod_q[2])
    else $error("register crc error did not set moderate bit 2");

  a_bist_set:
    assert property (@(posedge clk) disable iff (!rst_n)
      (logic_self_test_fail || analog_self_test_fail) |=> mod_q[1])
    else $error("self-test failure did not set moderate bit 1");

  a_tsd_seq_off:
    assert property (@(posedge clk) disable iff (!rst_n)
      $rose(thermal_sequenced_live) |=> mod_q[0] && sequenced_shutdown)
    else $error("sequenced thermal event not flagged or not acted on");

  a_tsd_block_en:
    assert property (@(posedge clk) disable iff (!rst_n)
      (mod_q[0] || sev_q[0]) |-> !regulator_enable)
    else $error("regulator enabled while a thermal flag is set");

  // gated on rst_n so the edge that releases reset is not judged
  a_live_follow:
    assert property (@(posedge clk) disable iff (!rst_n)
      rst_n |=> live_q == {$past(thermal_immediate_live),
                           $past(thermal_sequenced_live)})
    else $error("live thermal status does not track the inputs");

  a_severe_set:
    assert property (@(posedge clk) disable iff (!rst_n)
      sequencer_err || thermal_immediate_live |=> sev_q[2] || sev_q[0])
    else $error("sequencer or immediate thermal event not latched");

  a_seqr_set:
    assert property (@(posedge clk) disable iff (!rst_n)
      sequencer_err |=> sev_q[2])
    else $error("sequencer error did not set severe bit 2");

  a_tsd_imm_off:
    assert property (@(posedge clk) disable iff (!rst_n)
      thermal_immediate_live |=> sev_q[0] && immediate_shutdown &&
                                 !regulator_enable)
    else $error("immediate thermal did not latch and disable regulators");

  a_ovp_off:
    assert property (@(posedge clk) disable iff (!rst_n)
      supply_overvoltage |=> sev_q[1] && immediate_shutdown &&
                             !regulator_enable)
    else $error("over-voltage did not latch and disable regulators");

  a_w1c_clear:
    assert property (@(posedge clk) disable iff (!rst_n)
      wr_mod && wdat[2] && !mod_set[2] && mod_q[7] && !wdat[7]
      |=> !mod_q[2] && mod_q[7])
    else $error("write one did not clear only the written bit");

  a_sev_rsvd_rw:
    assert property (@(posedge clk) disable iff (!rst_n)
      wr_sev |=> sev_q[7:3] == $past(wdat[7:3]))
    else $error("severe reserved bits did not store written value");

  a_set_wins:
    assert property (@(posedge clk) disable iff (!rst_n)
      wr_mod && wdat[4] && pmic_link_err |=> mod_q[4])
    else $error("coincident clear lost a link error event");

  a_flag_holds:
    assert property (@(posedge clk) disable iff (!rst_n)
      sev_q[2] && !wr_sev |=> sev_q[2])
    else $error("severe flag dropped without a clearing write");

  a_mod_rsvd_rw:
    assert property (@(posedge clk) disable iff (!rst_n)
      wr_mod |=> mod_q[5] == $past(wdat[5]))
    else $error("moderate reserved bit did not store written value");

  a_mod_read:
    assert property (@(posedge clk) disable iff (!rst_n)
      dp_rd_q && dp_mapped_q && dp_idx_q == mse_pkg::IDX_MODERATE
      |-> hrdata == {24'h000000, mod_q})
    else $error("moderate register read returned wrong data");

  // expected level built from the flag layout, not from irq_d
  a_irq_level:
    assert property (@(posedge clk) disable iff (!rst_n)
      rst_n |=> irq == $past(|(mod_q & ~mod_mask_q & 8'hDF) ||
                             |(sev_q & ~sev_mask_q & 8'h07)))
    else $error("interrupt output does not follow unmasked flags");

endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the moderate and severe fault flag block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [9:0] ev;
    logic [7:0] cnt;
    logic [7:0] m;
    logic [7:0] s;
  } mse_row_t;
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [9:0]  ev;
  logic [7:0]  cnt;
  logic [7:0]  thr;
  logic        req;
  logic        reg_en;
  logic        seq_off;
  logic        imm_off;
  logic        irq;
  logic [31:0] rd_s;
  logic        rdy_s;
  int          failures;
  int          n_tests;
  mse_row_t    rows [12];

  mse_flags #(.CNT_W(8)) u_dut (
    .clk(clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hready(hready),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hready),
    .hresp(hresp),
    .reset_pin_readback_err(ev[9]),
    .irq_pin_readback_err(ev[8]),
    .pmic_link_err(ev[7]),
    .recovery_counter(cnt),
    .recovery_threshold(thr),
    .reg_crc_err(ev[6]),
    .logic_self_test_fail(ev[5]),
    .analog_self_test_fail(ev[4]),
    .thermal_sequenced_live(ev[3]),
    .sequencer_err(ev[2]),
    .supply_overvoltage(ev[1]),
    .thermal_immediate_live(ev[0]),
    .regulator_enable_req(req),
    .regulator_enable(reg_en),
    .sequenced_shutdown(seq_off),
    .immediate_shutdown(imm_off),
    .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // capture at the edge so read data never races the slave's own update
  always @(posedge clk) begin
    rd_s <= hrdata;
    rdy_s <= hready;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: pin %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (rdy_s !== 1'b1 && n < 20);
    if (rdy_s !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h000000, idx, 2'h0};
    htrans <= mse_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = rd_s;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, idx, {24'h000000, d}, x);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] x;
    bus(1'b0, idx, 32'h00000000, x);
    chk_reg(x, {24'h000000, e});
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    ev = 10'h000;
    cnt = 8'h00;
    thr = 8'h05;
    req = 1'b1;
    failures = 0;
    n_tests = 0;
    // event inputs, recovery count, expected moderate and severe flags
    rows = '{'{10'h200, 8'h00, 8'h80, 8'h00}, '{10'h100, 8'h00, 8'h40, 8'h00},
             '{10'h080, 8'h00, 8'h10, 8'h00}, '{10'h040, 8'h00, 8'h04, 8'h00},
             '{10'h020, 8'h00, 8'h02, 8'h00}, '{10'h010, 8'h00, 8'h02, 8'h00},
             '{10'h008, 8'h00, 8'h01, 8'h00}, '{10'h004, 8'h00, 8'h00, 8'h04},
             '{10'h002, 8'h00, 8'h00, 8'h02}, '{10'h001, 8'h00, 8'h00, 8'h01},
             '{10'h000, 8'h04, 8'h00, 8'h00}, '{10'h000, 8'h05, 8'h08, 8'h00}};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    rd_chk(mse_pkg::IDX_MODERATE, 8'h00);
    rd_chk(mse_pkg::IDX_SEVERE, 8'h00);
    chk_pin(reg_en, 1'b1);
    chk_pin(irq, 1'b0);
    chk_pin(hresp, 1'b0);
    foreach (rows[i]) begin
      ev <= rows[i].ev;
      cnt <= rows[i].cnt;
      settle();
      chk_pin(seq_off, rows[i].ev[3]);
      chk_pin(imm_off, rows[i].ev[1] | rows[i].ev[0]);
      rd_chk(mse_pkg::IDX_LIVE, {6'h00, rows[i].ev[0], rows[i].ev[3]});
      ev <= 10'h000;
      cnt <= 8'h00;
      rd_chk(mse_pkg::IDX_MODERATE, rows[i].m);
      rd_chk(mse_pkg::IDX_SEVERE, rows[i].s);
      chk_pin(irq, |{rows[i].m, rows[i].s});
      if (!rows[i].s[1]) begin
        chk_pin(reg_en, ~(rows[i].m[0] | rows[i].s[0]));
      end
      wr(mse_pkg::IDX_MODERATE, rows[i].m);
      wr(mse_pkg::IDX_SEVERE, rows[i].s);
      rd_chk(mse_pkg::IDX_MODERATE, 8'h00);
      rd_chk(mse_pkg::IDX_SEVERE, 8'h00);
      chk_pin(irq, 1'b0);
      chk_pin(reg_en, 1'b1);
    end
    // reserved bits hold data but never interrupt or block
    wr(mse_pkg::IDX_SEVERE, 8'hFF);
    wr(mse_pkg::IDX_MODERATE, 8'h20);
    rd_chk(mse_pkg::IDX_SEVERE, 8'hF8);
    rd_chk(mse_pkg::IDX_MODERATE, 8'h20);
    chk_pin(irq, 1'b0);
    chk_pin(reg_en, 1'b1);
    wr(mse_pkg::IDX_SEVERE, 8'h00);
    wr(mse_pkg::IDX_MODERATE, 8'h00);
    // two flags at once, both masked, then partial clear
    ev <= 10'h0C0;
    @(posedge clk);
    #1;
    ev <= 10'h000;
    wr(mse_pkg::IDX_MOD_MASK, 8'h14);
    settle();
    chk_pin(irq, 1'b0);
    wr(mse_pkg::IDX_MODERATE, 8'h10);
    rd_chk(mse_pkg::IDX_MODERATE, 8'h04);
    wr(mse_pkg::IDX_MOD_MASK, 8'h10);
    settle();
    chk_pin(irq, 1'b1);
    wr(mse_pkg::IDX_MODERATE, 8'h04);
    settle();
    chk_pin(irq, 1'b0);
    // clear write while the cause is still present must lose
    ev <= 10'h080;
    wr(mse_pkg::IDX_MODERATE, 8'h10);
    rd_chk(mse_pkg::IDX_MODERATE, 8'h10);
    ev <= 10'h000;
    wr(mse_pkg::IDX_MODERATE, 8'h10);
    rd_chk(mse_pkg::IDX_MODERATE, 8'h00);
    // a new threshold moves the recovery limit
    thr <= 8'h09;
    cnt <= 8'h05;
    settle();
    rd_chk(mse_pkg::IDX_MODERATE, 8'h00);
    cnt <= 8'h09;
    settle();
    cnt <= 8'h00;
    thr <= 8'h05;
    rd_chk(mse_pkg::IDX_MODERATE, 8'h08);
    wr(mse_pkg::IDX_MODERATE, 8'h08);
    // clearing one flag leaves another set flag alone
    ev <= 10'h240;
    @(posedge clk);
    #1;
    ev <= 10'h000;
    wr(mse_pkg::IDX_MODERATE, 8'h04);
    rd_chk(mse_pkg::IDX_MODERATE, 8'h80);
    wr(mse_pkg::IDX_MODERATE, 8'h80);
    rd_chk(mse_pkg::IDX_MODERATE, 8'h00);
    // unmapped index reads zero and ignores writes
    wr(8'h70, 8'hFF);
    rd_chk(8'h70, 8'h00);
    // reset in mid-run wipes flags and masks
    ev <= 10'h200;
    @(posedge clk);
    #1;
    ev <= 10'h000;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    rd_chk(mse_pkg::IDX_MODERATE, 8'h00);
    rd_chk(mse_pkg::IDX_MOD_MASK, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
